// file: ohi_pkg.sv
// Package for the display-module host interface: mode codes and shared constants.
// Assumes both ends and the bench import it.
package ohi_pkg;
  // ==========================================================
  // Interface select codes, bit order {sel2,sel1,sel0}
  localparam logic [2:0] OHI_SEL_I2C = 3'h2;
  localparam logic [2:0] OHI_SEL_SPI3 = 3'h1;
  localparam logic [2:0] OHI_SEL_SPI4 = 3'h0;
  localparam logic [2:0] OHI_SEL_PAR_E = 3'h4;
  localparam logic [2:0] OHI_SEL_PAR_RW = 3'h6;
  // ==========================================================
  // Bus pin roles in serial modes
  localparam int OHI_SCLK_BIT = 0;
  localparam int OHI_SERIAL_IN_BIT = 1;
  localparam int OHI_SDAO_BIT = 2;
  // ==========================================================
  // Host strobe timing in aclk cycles
  localparam int OHI_STROBE_CYC = 8;
  localparam int OHI_SCLK_HALF_CYC = 6;
  localparam logic [6:0] OHI_I2C_ADDR_BASE = 7'h3C;
  // Host register map (AXI4-Lite byte addresses)
  localparam logic [7:0] OHI_REG_CTRL = 8'h00;
  localparam logic [7:0] OHI_REG_WDATA = 8'h04;
  localparam logic [7:0] OHI_REG_STAT = 8'h08;
  localparam logic [7:0] OHI_REG_RDATA = 8'h0C;
  localparam logic [7:0] OHI_CMD_WRITE = 8'h01;
  localparam logic [7:0] OHI_CMD_READ = 8'h02;
endpackage : ohi_pkg

// file: ohi_if.sv
// Pin bundle between host controller and display module.
// Assumes the bench ties aclk; bus lines resolve from enables (pulls high when undriven).
`timescale 1ns/1ps
interface ohi_if;
  logic cs_n;
  logic init_n;
  logic dc;
  logic rw;
  logic en;
  logic [2:0] iface_sel;
  logic [7:0] host_bus_h;
  logic [7:0] host_bus_h_oe;
  logic [7:0] host_bus_d;
  logic [7:0] host_bus_d_oe;
  logic [7:0] host_bus;
  // Wired resolution: device wins even where host drives; open-drain SDA pulls high
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (host_bus_d_oe[i]) begin
        host_bus[i] = host_bus_d[i];
      end else if (host_bus_h_oe[i]) begin
        host_bus[i] = host_bus_h[i];
      end else begin
        host_bus[i] = 1'b1;
      end
    end
  end
  modport host (output cs_n, output init_n, output dc, output rw, output en,
    output iface_sel, output host_bus_h, output host_bus_h_oe, input host_bus);
  modport dev (input cs_n, input init_n, input dc, input rw, input en,
    input iface_sel, output host_bus_d, output host_bus_d_oe, input host_bus);
endinterface : ohi_if

// file: ohi_dev.sv
// Display-module end: receives data/command bytes over parallel or SPI, answers reads.
// Assumes pins are asynchronous to aclk; I2C framing beyond address-match is out of scope.
`timescale 1ns/1ps
import ohi_pkg::*;
// Notes on behaviour
// RQ1 - Transfers only honoured while select low
// RQ2 - Init low returns state to defaults
// RQ3 - Parallel: dc high means display data
// RQ4 - Parallel: dc low means command byte
// RQ5 - Serial: dc steers data versus command
// RQ6 - I2C: dc pin is address low bit
// RQ7 - Host drives rw high read, low write
// RQ8 - Enable mode: cycle starts on enable high
// RQ9 - Strobe mode: write on write-strobe low
// RQ10 - Strobe mode: read on read-strobe low
// RQ11 - Parallel bus is eight-bit bidirectional
// RQ12 - SPI: bit1 data in, bit0 clock
// RQ13 - I2C: bits 2,1 tied as SDA
// RQ14 - System sets interface select first
// RQ15 - Select codes per mode table
// RQ16 - SPI samples rising edge, MSB first
module ohi_dev (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pins
  ohi_if.dev pins,
  // User side
  output logic [7:0] rx_byte,
  output logic rx_is_data,
  output logic rx_valid,
  input wire logic [7:0] rd_byte,
  output logic [ohi_pkg::OHI_SDAO_BIT:0] i2c_addr_lsb_seen,
  output logic [6:0] i2c_slave_addr
);
  import ohi_pkg::*;
  // ==========================================================
  // Synchronisers
  logic [12:0] s1_q, s2_q, s3_q;
  logic [12:0] pin_raw;
  assign pin_raw = {pins.cs_n, pins.init_n, pins.dc, pins.rw, pins.en, pins.host_bus};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 13'h1800;
      s2_q <= 13'h1800;
      s3_q <= 13'h1800;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  logic cs_n, init_n, dc, rw, en, en_prev, sck, sck_prev;
  logic [7:0] bus;
  assign {cs_n, init_n, dc, rw, en, bus} = s2_q;
  assign en_prev = s3_q[8];
  assign sck = s2_q[OHI_SCLK_BIT];
  assign sck_prev = s3_q[OHI_SCLK_BIT];
  // Straps come from outside the clock domain, so they pass two flops too [RQ14]
  logic [2:0] sel, sel1_q, sel_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel1_q <= 3'h0;
      sel_q <= 3'h0;
    end else begin
      sel1_q <= pins.iface_sel;
      sel_q <= sel1_q;
    end
  end
  assign sel = sel_q;
  logic par_e, par_s, spi;
  assign par_e = (sel == OHI_SEL_PAR_E); // [RQ15]
  assign par_s = (sel == OHI_SEL_PAR_RW); // [RQ15]
  assign spi = (sel == OHI_SEL_SPI4) || (sel == OHI_SEL_SPI3); // [RQ15]
  // ==========================================================
  // Receive state
  logic [7:0] sh_q, sh_d, rx_q, rx_d;
  logic [2:0] cnt_q, cnt_d;
  logic dat_q, dat_d, vld_q, vld_d, rd_q, rd_d;
  logic [7:0] rdb_q, rdb_d;
  logic en_rise, wr_fall, rd_fall, sck_rise;
  assign en_rise = en && !en_prev;
  assign wr_fall = !rw && s3_q[9];
  assign rd_fall = !en && en_prev;
  assign sck_rise = sck && !sck_prev;
  always_comb begin
    sh_d = sh_q;
    cnt_d = cnt_q;
    rx_d = rx_q;
    dat_d = dat_q;
    vld_d = 1'b0;
    rd_d = rd_q;
    rdb_d = rdb_q;
    if (!init_n) begin // [RQ2]
      sh_d = 8'h00;
      cnt_d = 3'h0;
      rx_d = 8'h00;
      dat_d = 1'b0;
      rd_d = 1'b0;
    end else if (cs_n) begin // [RQ1]
      cnt_d = 3'h0;
      rd_d = 1'b0;
    end else if (par_e) begin
      if (en_rise && rw) begin // [RQ7] [RQ8]
        rd_d = 1'b1;
        rdb_d = rd_byte;
      end else if (en_rise) begin // [RQ8]
        rx_d = bus;
        dat_d = dc; // [RQ3] [RQ4]
        vld_d = 1'b1;
      end else if (!en) begin
        rd_d = 1'b0;
      end
    end else if (par_s) begin
      if (wr_fall) begin // [RQ9]
        rx_d = bus;
        dat_d = dc; // [RQ3] [RQ4]
        vld_d = 1'b1;
      end
      if (rd_fall) begin // [RQ10]
        rd_d = 1'b1;
        rdb_d = rd_byte;
      end else if (en) begin
        rd_d = 1'b0;
      end
    end else if (spi && sck_rise) begin // [RQ12] [RQ16]
      sh_d = {sh_q[6:0], bus[OHI_SERIAL_IN_BIT]};
      cnt_d = cnt_q + 3'h1;
      if (cnt_q == 3'h7) begin
        rx_d = {sh_q[6:0], bus[OHI_SERIAL_IN_BIT]};
        dat_d = dc; // [RQ5]
        vld_d = 1'b1;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sh_q <= 8'h00;
      cnt_q <= 3'h0;
      rx_q <= 8'h00;
      dat_q <= 1'b0;
      vld_q <= 1'b0;
      rd_q <= 1'b0;
      rdb_q <= 8'h00;
    end else begin
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      rx_q <= rx_d;
      dat_q <= dat_d;
      vld_q <= vld_d;
      rd_q <= rd_d;
      rdb_q <= rdb_d;
    end
  end
  assign rx_byte = rx_q;
  assign rx_is_data = dat_q;
  assign rx_valid = vld_q;
  // Drives the bus only during a read cycle in a parallel mode [RQ11]
  assign pins.host_bus_d = rdb_q;
  assign pins.host_bus_d_oe = {8{rd_q && (par_e || par_s) && !cs_n}};
  // In I2C mode the dc pin selects the address low bit [RQ6] [RQ13]
  assign i2c_slave_addr = {OHI_I2C_ADDR_BASE[6:1], dc};
  assign i2c_addr_lsb_seen = {bus[OHI_SDAO_BIT], bus[OHI_SERIAL_IN_BIT], dc};
endmodule : ohi_dev

// file: ohi_host.sv
// Host end: AXI4-Lite registers steer byte writes and reads to the module pins.
// Assumes a single AXI master, one write and one read outstanding.
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
import ohi_pkg::*;
module ohi_host (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  ohi_if.host pins
);
  import ohi_pkg::*;
  typedef enum logic [3:0] {
    OHI_IDLE = 4'h1, OHI_SETUP = 4'h2, OHI_STRB = 4'h4, OHI_HOLD = 4'h8
  } ohi_st_t;
  // ==========================================================
  // Register file: CTRL {sel[6:4], dc[1], init_n[0]}, WDATA, STAT busy, RDATA
  logic [6:0] ctrl_q, ctrl_d;
  logic [7:0] wd_q, wd_d, rdat_q, rdat_d;
  logic [1:0] cmd_q, cmd_d;
  logic aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
  logic [7:0] awa_q, awa_d;
  logic [31:0] wdat_q, wdat_d, rd_q, rd_d;
  ohi_st_t st_q, st_d;
  logic [3:0] tm_q, tm_d;
  logic [1:0] err_q, err_d;
  assign s_axi_awready = !aw_q && !b_q;
  assign s_axi_wready = !w_q && !b_q;
  assign s_axi_arready = !r_q;
  assign s_axi_bvalid = b_q;
  assign s_axi_bresp = err_q;
  assign s_axi_rvalid = r_q;
  assign s_axi_rdata = rd_q;
  assign s_axi_rresp = 2'h0;
  always_comb begin
    aw_d = aw_q; w_d = w_q; b_d = b_q; r_d = r_q;
    awa_d = awa_q; wdat_d = wdat_q; rd_d = rd_q; err_d = err_q;
    ctrl_d = ctrl_q; wd_d = wd_q; cmd_d = 2'h0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_d = 1'b1; awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_d = 1'b1; wdat_d = s_axi_wdata;
    end
    if (aw_q && w_q) begin
      aw_d = 1'b0; w_d = 1'b0; b_d = 1'b1; err_d = 2'h0;
      unique case (awa_q)
        OHI_REG_CTRL: ctrl_d = wdat_q[6:0];
        OHI_REG_WDATA: begin
          wd_d = wdat_q[7:0];
          cmd_d = wdat_q[9:8];
        end
        OHI_REG_STAT, OHI_REG_RDATA: ;
        default: err_d = 2'h2;
      endcase
    end
    if (b_q && s_axi_bready) b_d = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      r_d = 1'b1;
      unique case (s_axi_araddr)
        OHI_REG_CTRL: rd_d = {25'h0, ctrl_q};
        OHI_REG_WDATA: rd_d = {24'h0, wd_q};
        OHI_REG_STAT: rd_d = {31'h0, st_q != OHI_IDLE};
        OHI_REG_RDATA: rd_d = {24'h0, rdat_q};
        default: rd_d = 32'h0;
      endcase
    end
    if (r_q && s_axi_rready) r_d = 1'b0;
  end
  // ==========================================================
  // Pin sequencer: one parallel or serial byte cycle per command
  logic is_rd_q, is_rd_d;
  logic par_e, spi;
  logic [3:0] ph_q, ph_d;
  assign par_e = (ctrl_q[6:4] == OHI_SEL_PAR_E);
  assign spi = (ctrl_q[6:4] == OHI_SEL_SPI3) || (ctrl_q[6:4] == OHI_SEL_SPI4);
  always_comb begin
    st_d = st_q; tm_d = tm_q; is_rd_d = is_rd_q; rdat_d = rdat_q; ph_d = ph_q;
    unique case (st_q)
      OHI_IDLE: if (cmd_q != 2'h0 && st_q == OHI_IDLE) begin
        is_rd_d = (cmd_q == 2'h2); st_d = OHI_SETUP; tm_d = 4'h0; ph_d = 4'h0;
      end
      OHI_SETUP: begin
        tm_d = tm_q + 4'h1;
        if (tm_q == 4'(OHI_STROBE_CYC - 1)) begin st_d = OHI_STRB; tm_d = 4'h0; end
      end
      OHI_STRB: begin
        tm_d = tm_q + 4'h1;
        // Serial modes: 16 half periods of the divided link clock
        if (spi) begin
          if (tm_q == 4'(OHI_SCLK_HALF_CYC - 1)) begin
            tm_d = 4'h0;
            ph_d = ph_q + 4'h1;
            if (ph_q == 4'hF) st_d = OHI_HOLD;
          end
        end else if (tm_q == 4'(OHI_STROBE_CYC - 1)) begin
          st_d = OHI_HOLD; tm_d = 4'h0;
          if (is_rd_q) rdat_d = pins.host_bus;
        end
      end
      OHI_HOLD: begin
        tm_d = tm_q + 4'h1;
        if (tm_q == 4'(OHI_STROBE_CYC - 1)) st_d = OHI_IDLE;
      end
      default: st_d = OHI_IDLE;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0; w_q <= 1'b0; b_q <= 1'b0; r_q <= 1'b0;
      awa_q <= 8'h00; wdat_q <= 32'h0; rd_q <= 32'h0; err_q <= 2'h0;
      ctrl_q <= 7'h00; wd_q <= 8'h00; cmd_q <= 2'h0; rdat_q <= 8'h00;
      st_q <= OHI_IDLE; tm_q <= 4'h0; is_rd_q <= 1'b0; ph_q <= 4'h0;
    end else begin
      ph_q <= ph_d;
      aw_q <= aw_d; w_q <= w_d; b_q <= b_d; r_q <= r_d;
      awa_q <= awa_d; wdat_q <= wdat_d; rd_q <= rd_d; err_q <= err_d;
      ctrl_q <= ctrl_d; wd_q <= wd_d; cmd_q <= cmd_d; rdat_q <= rdat_d;
      st_q <= st_d; tm_q <= tm_d; is_rd_q <= is_rd_d;
    end
  end
  // Select low for the whole cycle [RQ1]
  logic strb;
  assign strb = (st_q == OHI_STRB);
  assign pins.cs_n = (st_q == OHI_IDLE);
  assign pins.init_n = ctrl_q[0]; // [RQ2]
  assign pins.dc = ctrl_q[1];
  assign pins.iface_sel = ctrl_q[6:4]; // [RQ14] [RQ15]
  // Enable mode: rw level, enable high strobe; strobe mode: active-low strobes
  assign pins.rw = par_e ? is_rd_q : !(strb && !is_rd_q); // [RQ7] [RQ8] [RQ9]
  assign pins.en = par_e ? strb : !(strb && is_rd_q); // [RQ8] [RQ10]
  // Link clock low then high per bit, data set MSB first while it is low [RQ12] [RQ16]
  logic sclk, sdo;
  assign sclk = strb && ph_q[0];
  assign sdo = wd_q[~ph_q[3:1]];
  assign pins.host_bus_h = spi ? {6'h3F, sdo, sclk} : wd_q;
  assign pins.host_bus_h_oe = {8{(st_q != OHI_IDLE) && !is_rd_q}}; // [RQ11]
endmodule : ohi_host

// file: ohi_assertions.sv
// Checker on the pin bundle between host end and module end.
// Assumes it sits beside the interface and shares aclk and aresetn with both ends.
`timescale 1ns/1ps
module ohi_assertions
  import ohi_pkg::*;
(
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // Pins
  input logic cs_n,
  input logic init_n,
  input logic rw,
  input logic en,
  input logic [2:0] iface_sel,
  input logic [7:0] host_bus_h,
  input logic [7:0] host_bus_h_oe,
  input logic [7:0] host_bus_d_oe
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Pins cross two sync flops, so the module answers with a short lag
  sequence s_drive_all;
    ##[1:6] host_bus_d_oe == 8'hFF;
  endsequence
  a_idle_deselect: assert property (cs_n [*4] |-> host_bus_d_oe == 8'h00)
    else $error("module drives bus while deselected");
  a_idle_init: assert property (!init_n [*4] |-> host_bus_d_oe == 8'h00)
    else $error("module drives bus during init");
  a_spi_quiet: assert property ((iface_sel[2:1] == 2'b00) [*4] |-> host_bus_d_oe == 8'h00)
    else $error("module drives bus in serial mode");
  a_strobe_select: assert property ($rose(en) && iface_sel == OHI_SEL_PAR_E |-> !cs_n)
    else $error("enable strobe without select");
  a_write_select: assert property ($fell(rw) && iface_sel == OHI_SEL_PAR_RW |-> !cs_n)
    else $error("write strobe without select");
  a_read_drive_e: assert property ($rose(en) && rw && !cs_n && iface_sel == OHI_SEL_PAR_E
    |-> s_drive_all)
    else $error("no read drive in enable mode");
  a_read_drive_rd: assert property ($fell(en) && !cs_n && iface_sel == OHI_SEL_PAR_RW
    |-> s_drive_all)
    else $error("no read drive on read strobe");
  a_no_contention: assert property (host_bus_d_oe != 8'h00 |-> host_bus_h_oe == 8'h00)
    else $error("both ends drive the bus");
  a_write_steady: assert property (en && $past(en) && !rw && !cs_n
    && iface_sel == OHI_SEL_PAR_E |-> $stable(host_bus_h))
    else $error("write data moved during strobe");
endmodule : ohi_assertions

// file: oled_module_host_interface_test.sv
// Bench joining host end and module end through the pin bundle.
// Assumes AXI4-Lite register map and pin timing of the host end as handed over.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module oled_module_host_interface_test;
  import ohi_pkg::*;
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr, rd_byte, rx_byte, last_byte;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic rx_is_data, rx_valid, last_dc;
  logic [6:0] i2c_slave_addr;
  int n_errors = 0, num_checks = 0, rx_cnt = 0, cyc = 0;
  ohi_if bus();
  ohi_host ohi_host_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pins(bus));
  ohi_dev ohi_dev_i (.aclk, .aresetn, .pins(bus), .rx_byte, .rx_is_data, .rx_valid,
    .rd_byte, .i2c_addr_lsb_seen(), .i2c_slave_addr);
  ohi_assertions ohi_assertions_i (.aclk, .aresetn, .cs_n(bus.cs_n), .init_n(bus.init_n),
    .rw(bus.rw), .en(bus.en), .iface_sel(bus.iface_sel), .host_bus_h(bus.host_bus_h),
    .host_bus_h_oe(bus.host_bus_h_oe), .host_bus_d_oe(bus.host_bus_d_oe));
  // ==========================================================
  // Clock, timeout, receive capture
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (rx_valid === 1'b1) begin
      rx_cnt <= rx_cnt + 1;
      last_byte <= rx_byte;
      last_dc <= rx_is_data;
    end
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end
  // ==========================================================
  // Expectations and bus tasks
  function automatic logic [31:0] ctrl_word(logic [2:0] s, logic dcb, logic ini);
    return {25'h0, s, 2'b00, dcb, ini};
  endfunction : ctrl_word
  function automatic logic [6:0] exp_addr(logic dcb);
    return {OHI_I2C_ADDR_BASE[6:1], dcb};
  endfunction : exp_addr
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  // Parallel pin cycles take 24 clocks, serial ones 112; poll busy rather than count them
  task automatic cmd(input logic [31:0] w);
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(OHI_REG_WDATA, w, r);
    do axi_rd(OHI_REG_STAT, d);
    while (d[0] !== 1'b0);
    repeat (4) @(posedge aclk);
  endtask : cmd
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  // ==========================================================
  // Main sequence
  initial begin
    logic [2:0] md;
    logic [2:0] modes [3] = '{OHI_SEL_SPI3, OHI_SEL_SPI4, OHI_SEL_I2C};
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] b;
    int n;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rd_byte} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    void'($urandom(32'hB9C2));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      md = m ? OHI_SEL_PAR_RW : OHI_SEL_PAR_E;
      for (int i = 0; i < 6; i++) begin
        b = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
        axi_wr(OHI_REG_CTRL, ctrl_word(md, i[0], 1'b1), r);
        n = rx_cnt;
        cmd({22'h0, 2'b01, b});
        `CHK("rx count", n + 1, rx_cnt)
        `CHK("rx byte", b, last_byte)
        `CHK("rx kind", i[0], last_dc)
      end
      rd_byte <= 8'($urandom);
      cmd(32'h200);
      axi_rd(OHI_REG_RDATA, d);
      `CHK("read byte", rd_byte, d[7:0])
    end
    axi_wr(OHI_REG_CTRL, ctrl_word(OHI_SEL_PAR_E, 1'b1, 1'b0), r);
    n = rx_cnt;
    cmd(32'h15A);
    `CHK("rx in init", n, rx_cnt)
    for (int j = 0; j < 6; j++) begin
      md = modes[j / 2];
      axi_wr(OHI_REG_CTRL, ctrl_word(md, j[0], 1'b1), r);
      repeat (4) @(posedge aclk);
      `CHK("select pins", md, bus.iface_sel)
      if (md == OHI_SEL_I2C) `CHK("i2c address", exp_addr(j[0]), i2c_slave_addr)
      if (md != OHI_SEL_I2C) begin
        b = (j == 0) ? 8'h81 : 8'($urandom);
        n = rx_cnt;
        cmd({22'h0, 2'b01, b});
        `CHK("spi count", n + 1, rx_cnt)
        `CHK("spi byte", b, last_byte)
        `CHK("spi kind", j[0], last_dc)
      end
    end
    axi_wr(8'h10, 32'h5A, r);
    `CHK("unmapped write", 2'h2, r)
    axi_rd(8'h10, d);
    `CHK("unmapped read", 32'h0, d)
    close_out();
  end
endmodule : oled_module_host_interface_test
